//--- aod_arith_decoder.sv
// Top of the arithmetic opcode decoder: walks the byte stream of one instruction.
`timescale 1ns/100ps
`include "aod_defs.svh"
module aod_arith_decoder
  import aod_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Instruction byte stream
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  // Decoded instruction
  output logic             instrValid,
  output logic             foreignValid,
  output aod_op_e          opKind,
  output aod_form_e        opForm,
  output logic [7:0]       opcodeOut,
  output logic             dirToReg,
  output logic             wide,
  output logic             signExt,
  output logic             hasAddrByte,
  output logic [7:0]       addrByte,
  output logic [1:0]       dispCount,
  output logic [1:0]       immCount,
  output logic [15:0]      immValue
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Displacement bytes implied by the addressing byte.
  function automatic logic [1:0] dispOf(input logic [7:0] m);
    logic [1:0] md;
    md = m[`AOD_MOD_HI:`AOD_MOD_LO];
    if (md == `AOD_MOD_DISP8) begin
      dispOf = 2'h1;
    end else if (md == `AOD_MOD_DISP16) begin
      dispOf = 2'h2;
    end else if (md == `AOD_MOD_NODISP && m[`AOD_RM_HI:`AOD_RM_LO] == `AOD_RM_DIRECT) begin
      dispOf = 2'h2;
    end else begin
      dispOf = 2'h0;
    end
  endfunction : dispOf

  aod_class_if cls ();
  assign cls.opcode = byteData;

  aod_opcode_classify u_classify (
    .cls (cls.classifier)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  aod_state_e state_q;
  aod_op_e    op_q;
  aod_form_e  form_q;
  logic [7:0] opc_q;
  logic       dir_q;
  logic       wide_q;
  logic       sext_q;
  logic [7:0] modrm_q;
  logic       hasAddr_q;
  logic [1:0] disp_q;
  logic [1:0] dispLeft_q;
  logic [1:0] imm_q;
  logic [1:0] immLeft_q;
  logic [7:0] immLo_q;
  logic       done;
  logic       foreign;
  logic [2:0] mid;
  aod_op_e    midOp;
  logic       midOk;

  assign mid = byteData[`AOD_MID_HI:`AOD_MID_LO];

  always_comb begin
    midOk = 1'b1;
    case (mid)
      `AOD_MID_ADD: midOp = AOD_OP_ADD;
      `AOD_MID_ADC: midOp = AOD_OP_ADC;
      `AOD_MID_SUB: midOp = AOD_OP_SUB;
      `AOD_MID_SBB: midOp = AOD_OP_SBB;
      default: begin
        midOp = AOD_OP_ADD;
        midOk = 1'b0;
      end
    endcase
  end

  // A group opcode whose middle field is not arithmetic belongs to a neighbour.
  always_comb begin
    done    = 1'b0;
    foreign = 1'b0;
    if (byteValid) begin
      case (state_q)
        AOD_ST_OPC: begin
          foreign = !cls.isArith;
          done    = cls.isArith && cls.form == AOD_FORM_SINGLE;
        end
        AOD_ST_ADDR: begin
          foreign = form_q == AOD_FORM_IMMRM && !midOk;
          done    = !foreign && dispOf(byteData) == 2'h0 && imm_q == 2'h0;
        end
        AOD_ST_DISP: done = dispLeft_q == 2'h1 && imm_q == 2'h0;
        AOD_ST_IMM:  done = immLeft_q == 2'h1;
        default:     done = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= AOD_ST_OPC;
      op_q       <= AOD_OP_ADD;
      form_q     <= AOD_FORM_REGMEM;
      opc_q      <= `AOD_RST_BYTE;
      dir_q      <= 1'b0;
      wide_q     <= 1'b0;
      sext_q     <= 1'b0;
      modrm_q    <= `AOD_RST_BYTE;
      hasAddr_q  <= 1'b0;
      disp_q     <= `AOD_RST_CNT;
      dispLeft_q <= `AOD_RST_CNT;
      imm_q      <= `AOD_RST_CNT;
      immLeft_q  <= `AOD_RST_CNT;
      immLo_q    <= `AOD_RST_BYTE;
    end else if (byteValid) begin
      case (state_q)
        AOD_ST_OPC: begin
          opc_q     <= byteData;
          op_q      <= cls.op;
          form_q    <= cls.form;
          dir_q     <= cls.dirToReg;
          wide_q    <= cls.wide;
          sext_q    <= cls.signExt;
          imm_q     <= cls.immBytes;
          immLeft_q <= cls.immBytes;
          hasAddr_q <= 1'b0;
          modrm_q   <= `AOD_RST_BYTE;
          disp_q    <= `AOD_RST_CNT;
          if (cls.isArith && cls.form == AOD_FORM_ACCUM) begin
            state_q <= AOD_ST_IMM;
          end else if (cls.isArith && cls.form != AOD_FORM_SINGLE) begin
            state_q <= AOD_ST_ADDR;
          end
        end
        AOD_ST_ADDR: begin
          modrm_q    <= byteData;
          hasAddr_q  <= 1'b1;
          disp_q     <= dispOf(byteData);
          dispLeft_q <= dispOf(byteData);
          if (form_q == AOD_FORM_IMMRM) begin
            op_q <= midOp;
          end
          if (foreign || done) begin
            state_q <= AOD_ST_OPC;
          end else if (dispOf(byteData) != 2'h0) begin
            state_q <= AOD_ST_DISP;
          end else begin
            state_q <= AOD_ST_IMM;
          end
        end
        AOD_ST_DISP: begin
          dispLeft_q <= dispLeft_q - 2'h1;
          if (done) begin
            state_q <= AOD_ST_OPC;
          end else if (dispLeft_q == 2'h1) begin
            state_q <= AOD_ST_IMM;
          end
        end
        AOD_ST_IMM: begin
          immLeft_q <= immLeft_q - 2'h1;
          immLo_q   <= byteData;
          if (done) begin
            state_q <= AOD_ST_OPC;
          end
        end
        default: state_q <= AOD_ST_OPC;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Result registers
  // --------------------------------------------------------------------------
  logic [15:0] immNext;

  // A single immediate byte with s:w=11 is sign-extended; otherwise zero above.
  always_comb begin
    if (state_q != AOD_ST_IMM) begin
      immNext = `AOD_RST_WORD;
    end else if (imm_q == 2'h2) begin
      immNext = {byteData, immLo_q};
    end else if (form_q == AOD_FORM_IMMRM && sext_q && wide_q) begin
      immNext = {{8{byteData[7]}}, byteData};
    end else begin
      immNext = {8'h00, byteData};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instrValid   <= 1'b0;
      foreignValid <= 1'b0;
      opKind       <= AOD_OP_ADD;
      opForm       <= AOD_FORM_REGMEM;
      opcodeOut    <= `AOD_RST_BYTE;
      dirToReg     <= 1'b0;
      wide         <= 1'b0;
      signExt      <= 1'b0;
      hasAddrByte  <= 1'b0;
      addrByte     <= `AOD_RST_BYTE;
      dispCount    <= `AOD_RST_CNT;
      immCount     <= `AOD_RST_CNT;
      immValue     <= `AOD_RST_WORD;
    end else begin
      instrValid   <= done;
      foreignValid <= foreign;
      if (done && state_q == AOD_ST_OPC) begin
        opKind      <= cls.op;
        opForm      <= cls.form;
        opcodeOut   <= byteData;
        dirToReg    <= 1'b0;
        wide        <= 1'b0;
        signExt     <= 1'b0;
        hasAddrByte <= 1'b0;
        addrByte    <= `AOD_RST_BYTE;
        dispCount   <= `AOD_RST_CNT;
        immCount    <= `AOD_RST_CNT;
        immValue    <= `AOD_RST_WORD;
      end else if (done) begin
        opKind      <= (state_q == AOD_ST_ADDR && form_q == AOD_FORM_IMMRM) ? midOp : op_q;
        opForm      <= form_q;
        opcodeOut   <= opc_q;
        dirToReg    <= dir_q;
        wide        <= wide_q;
        signExt     <= sext_q;
        hasAddrByte <= hasAddr_q || state_q == AOD_ST_ADDR;
        addrByte    <= (state_q == AOD_ST_ADDR) ? byteData : modrm_q;
        dispCount   <= (state_q == AOD_ST_ADDR) ? `AOD_RST_CNT : disp_q;
        immCount    <= imm_q;
        immValue    <= immNext;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  add_regmem_a : assert property (@(posedge clk) disable iff (!reset_n)
    instrValid && opcodeOut[7:2] == 6'b000000 |->
      opKind == AOD_OP_ADD && opForm == AOD_FORM_REGMEM && hasAddrByte && immCount == 2'h0)
    else $error("add register form decoded wrongly");

  adc_imm_a : assert property (@(posedge clk) disable iff (!reset_n)
    instrValid && opcodeOut[7:2] == 6'b100000 && addrByte[5:3] == 3'b010 |->
      opKind == AOD_OP_ADC && immCount == ((opcodeOut[1:0] == 2'b01) ? 2'h2 : 2'h1))
    else $error("add with carry immediate decoded wrongly");

  ascii_add_a : assert property (@(posedge clk) disable iff (!reset_n)
    state_q == AOD_ST_OPC && byteValid && byteData == 8'h37 |=>
      instrValid && opKind == AOD_OP_AAA && !hasAddrByte && immCount == 2'h0)
    else $error("ascii adjust after add not single byte");

  decimal_add_a : assert property (@(posedge clk) disable iff (!reset_n)
    state_q == AOD_ST_OPC && byteValid && byteData == 8'h27 |=>
      instrValid && opKind == AOD_OP_DAA && !hasAddrByte && immCount == 2'h0)
    else $error("decimal adjust after add not single byte");

  sub_accum_a : assert property (@(posedge clk) disable iff (!reset_n)
    instrValid && opcodeOut[7:1] == 7'b0010110 |->
      opKind == AOD_OP_SUB && !hasAddrByte && immCount == {opcodeOut[0], !opcodeOut[0]})
    else $error("subtract accumulator immediate count wrong");

  sbb_forms_a : assert property (@(posedge clk) disable iff (!reset_n)
    instrValid && (opcodeOut[7:2] == 6'b000110 || opcodeOut[7:1] == 7'b0001110) |->
      opKind == AOD_OP_SBB)
    else $error("subtract with borrow decoded wrongly");

  ascii_sub_a : assert property (@(posedge clk) disable iff (!reset_n)
    state_q == AOD_ST_OPC && byteValid && byteData == 8'h3F |=>
      instrValid && opKind == AOD_OP_AAS && opForm == AOD_FORM_SINGLE)
    else $error("ascii adjust after subtract not single byte");

  sign_extend_a : assert property (@(posedge clk) disable iff (!reset_n)
    instrValid && opForm == AOD_FORM_IMMRM && opcodeOut[1:0] == 2'b11 |->
      immCount == 2'h1 && immValue[15:8] == {8{immValue[7]}} && wide && signExt)
    else $error("sign-extended immediate wrong");

endmodule : aod_arith_decoder

//--- aod_class_if.sv
// Carrier for the opcode classification between classifier and decoder.
`timescale 1ns/100ps
interface aod_class_if;
  import aod_pkg::*;
  logic [7:0] opcode;
  logic       isArith;
  aod_op_e    op;
  aod_form_e  form;
  logic       dirToReg;
  logic       wide;
  logic       signExt;
  logic [1:0] immBytes;

  modport classifier (input opcode, output isArith, op, form, dirToReg, wide, signExt, immBytes);
  modport decoder    (output opcode, input isArith, op, form, dirToReg, wide, signExt, immBytes);
endinterface : aod_class_if

//--- aod_defs.svh
// Opcode patterns, masks, field positions and reset values of the arithmetic decoder.
`ifndef AOD_DEFS_SVH
`define AOD_DEFS_SVH

// ----------------------------------------------------------------------------
// Opcode patterns and masks
// ----------------------------------------------------------------------------
`define AOD_MASK_RM      8'hFC
`define AOD_MASK_ACC     8'hFE
`define AOD_OPC_ADD_RM   8'h00
`define AOD_OPC_ADC_RM   8'h10
`define AOD_OPC_SBB_RM   8'h18
`define AOD_OPC_SUB_RM   8'h28
`define AOD_OPC_IMM_GRP  8'h80
`define AOD_OPC_ADD_ACC  8'h04
`define AOD_OPC_ADC_ACC  8'h14
`define AOD_OPC_SBB_ACC  8'h1C
`define AOD_OPC_SUB_ACC  8'h2C
`define AOD_OPC_AAA      8'h37
`define AOD_OPC_DAA      8'h27
`define AOD_OPC_AAS      8'h3F

// ----------------------------------------------------------------------------
// Middle field of the addressing byte in the immediate group
// ----------------------------------------------------------------------------
`define AOD_MID_ADD      3'h0
`define AOD_MID_ADC      3'h2
`define AOD_MID_SBB      3'h3
`define AOD_MID_SUB      3'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AOD_BIT_W        0
`define AOD_BIT_D        1
`define AOD_BIT_S        1
`define AOD_MID_HI       5
`define AOD_MID_LO       3
`define AOD_MOD_HI       7
`define AOD_MOD_LO       6
`define AOD_RM_HI        2
`define AOD_RM_LO        0
`define AOD_MOD_NODISP   2'h0
`define AOD_MOD_DISP8    2'h1
`define AOD_MOD_DISP16   2'h2
`define AOD_RM_DIRECT    3'h6
`define AOD_SW_TWO_IMM   2'h1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AOD_RST_BYTE     8'h00
`define AOD_RST_WORD     16'h0000
`define AOD_RST_CNT      2'h0

`endif

//--- aod_fetch_model.sv
// Behavioural instruction fetch stream that feeds the decoder at most one byte per cycle.
`timescale 1ns/100ps
module aod_fetch_model (
  // Clock
  input  wire logic        clk,
  // Byte stream
  output logic             byteValid,
  output logic [7:0]       byteData
);
  logic [7:0] q[$];
  int         gap;
  int         waitCnt;

  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
    gap = 0;
    waitCnt = 0;
  end

  // ---------------------------------------------------------------------------
  // Byte launch
  // ---------------------------------------------------------------------------
  // Idle cycles invert the data shown the cycle before, so stale data never holds still
  // as if fresh; gap inserts stall cycles between bytes.
  always @(negedge clk) begin
    if (q.size() != 0 && waitCnt >= gap) begin
      byteValid <= 1'b1;
      byteData <= q.pop_front();
      waitCnt <= 0;
    end else begin
      byteValid <= 1'b0;
      byteData <= ~byteData;
      waitCnt <= waitCnt + 1;
    end
  end
endmodule : aod_fetch_model

//--- aod_opcode_classify.sv
// Combinational classification of the first byte of an arithmetic instruction.
`timescale 1ns/100ps
`include "aod_defs.svh"
module aod_opcode_classify
  import aod_pkg::*;
(
  // Classification carrier
  aod_class_if.classifier cls
);

  logic [7:0] b;
  assign b = cls.opcode;

  always_comb begin
    cls.isArith  = 1'b1;
    cls.op       = AOD_OP_ADD;
    cls.form     = AOD_FORM_REGMEM;
    cls.dirToReg = b[`AOD_BIT_D];
    cls.wide     = b[`AOD_BIT_W];
    cls.signExt  = 1'b0;
    cls.immBytes = 2'h0;
    if ((b & `AOD_MASK_RM) == `AOD_OPC_ADD_RM) begin
      cls.op = AOD_OP_ADD;
    end else if ((b & `AOD_MASK_RM) == `AOD_OPC_ADC_RM) begin
      cls.op = AOD_OP_ADC;
    end else if ((b & `AOD_MASK_RM) == `AOD_OPC_SUB_RM) begin
      cls.op = AOD_OP_SUB;
    end else if ((b & `AOD_MASK_RM) == `AOD_OPC_SBB_RM) begin
      cls.op = AOD_OP_SBB;
    end else if ((b & `AOD_MASK_RM) == `AOD_OPC_IMM_GRP) begin
      // The operation is only known once the middle field arrives.
      cls.form     = AOD_FORM_IMMRM;
      cls.dirToReg = 1'b0;
      cls.signExt  = b[`AOD_BIT_S];
      cls.immBytes = (b[1:0] == `AOD_SW_TWO_IMM) ? 2'h2 : 2'h1;
    end else if ((b & `AOD_MASK_ACC) == `AOD_OPC_ADD_ACC ||
                 (b & `AOD_MASK_ACC) == `AOD_OPC_ADC_ACC ||
                 (b & `AOD_MASK_ACC) == `AOD_OPC_SUB_ACC ||
                 (b & `AOD_MASK_ACC) == `AOD_OPC_SBB_ACC) begin
      cls.form     = AOD_FORM_ACCUM;
      cls.dirToReg = 1'b1;
      cls.immBytes = b[`AOD_BIT_W] ? 2'h2 : 2'h1;
      case (b & `AOD_MASK_ACC)
        `AOD_OPC_ADD_ACC: cls.op = AOD_OP_ADD;
        `AOD_OPC_ADC_ACC: cls.op = AOD_OP_ADC;
        `AOD_OPC_SUB_ACC: cls.op = AOD_OP_SUB;
        default:          cls.op = AOD_OP_SBB;
      endcase
    end else if (b == `AOD_OPC_AAA || b == `AOD_OPC_DAA || b == `AOD_OPC_AAS) begin
      cls.form     = AOD_FORM_SINGLE;
      cls.dirToReg = 1'b0;
      cls.wide     = 1'b0;
      case (b)
        `AOD_OPC_AAA: cls.op = AOD_OP_AAA;
        `AOD_OPC_DAA: cls.op = AOD_OP_DAA;
        default:      cls.op = AOD_OP_AAS;
      endcase
    end else begin
      cls.isArith = 1'b0;
    end
  end

endmodule : aod_opcode_classify

//--- aod_pkg.sv
// Types shared by the arithmetic opcode decoder modules.
package aod_pkg;

  typedef enum logic [2:0] {
    AOD_OP_ADD = 3'h0,
    AOD_OP_ADC = 3'h1,
    AOD_OP_SUB = 3'h2,
    AOD_OP_SBB = 3'h3,
    AOD_OP_AAA = 3'h4,
    AOD_OP_DAA = 3'h5,
    AOD_OP_AAS = 3'h6
  } aod_op_e;

  typedef enum logic [1:0] {
    AOD_FORM_REGMEM = 2'h0,
    AOD_FORM_IMMRM  = 2'h1,
    AOD_FORM_ACCUM  = 2'h2,
    AOD_FORM_SINGLE = 2'h3
  } aod_form_e;

  typedef enum logic [3:0] {
    AOD_ST_OPC  = 4'b0001,
    AOD_ST_ADDR = 4'b0010,
    AOD_ST_DISP = 4'b0100,
    AOD_ST_IMM  = 4'b1000
  } aod_state_e;

endpackage : aod_pkg

//--- arith_opcode_decoder_tb.sv
// Self-checking bench for the arithmetic opcode decoder.
`timescale 1ns/100ps
module arith_opcode_decoder_tb;
  import aod_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        byteValid;
  logic [7:0]  byteData;
  logic        instrValid;
  logic        foreignValid;
  aod_op_e     opKind;
  aod_form_e   opForm;
  logic [7:0]  opcodeOut;
  logic        dirToReg;
  logic        wide;
  logic        signExt;
  logic        hasAddrByte;
  logic [7:0]  addrByte;
  logic [1:0]  dispCount;
  logic [1:0]  immCount;
  logic [15:0] immValue;
  int          num_errors;
  int          cmp_count;

  aod_fetch_model u_fetch (.clk(clk), .byteValid(byteValid), .byteData(byteData));

  aod_arith_decoder u_dut (
    .clk(clk), .reset_n(reset_n), .byteValid(byteValid), .byteData(byteData),
    .instrValid(instrValid), .foreignValid(foreignValid), .opKind(opKind),
    .opForm(opForm), .opcodeOut(opcodeOut), .dirToReg(dirToReg), .wide(wide),
    .signExt(signExt), .hasAddrByte(hasAddrByte), .addrByte(addrByte),
    .dispCount(dispCount), .immCount(immCount), .immValue(immValue)
  );

  always #5 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic feed(input logic [7:0] b[$]);
    @(posedge clk);
    #1;
    foreach (b[i]) u_fetch.q.push_back(b[i]);
  endtask : feed

  // Waits for the next pulse; expN > 0 also checks the cycles waited since the task was called.
  task automatic await(input logic frn, input int expN);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instrValid !== 1'b1 && foreignValid !== 1'b1 && n < 40);
    chk("foreignValid", foreignValid, frn);
    chk("instrValid", instrValid, !frn);
    if (expN > 0) chk("latency", n, expN);
  endtask : await

  // Flags are packed as {dirToReg, wide, signExt, hasAddrByte}.
  task automatic fields(input aod_op_e k, input aod_form_e f, input logic [7:0] opc,
                        input logic [3:0] fl, input logic [7:0] a, input logic [1:0] dc,
                        input logic [1:0] ic, input logic [15:0] iv);
    chk("opKind", opKind, k);
    chk("opForm", opForm, f);
    chk("opcodeOut", opcodeOut, opc);
    chk("flags", {dirToReg, wide, signExt, hasAddrByte}, fl);
    chk("addrByte", addrByte, a);
    chk("dispCount", dispCount, dc);
    chk("immCount", immCount, ic);
    chk("immValue", immValue, iv);
  endtask : fields

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic run_add;
    feed('{8'h01, 8'hD8, 8'h05, 8'h34, 8'h12, 8'h80, 8'h06, 8'h34, 8'h12, 8'h56});
    await(1'b0, 2);
    fields(AOD_OP_ADD, AOD_FORM_REGMEM, 8'h01, 4'h5, 8'hD8, 0, 0, 16'h0000);
    await(1'b0, 3);
    fields(AOD_OP_ADD, AOD_FORM_ACCUM, 8'h05, 4'hC, 8'h00, 0, 2, 16'h1234);
    await(1'b0, 5);
    fields(AOD_OP_ADD, AOD_FORM_IMMRM, 8'h80, 4'h1, 8'h06, 2, 1, 16'h0056);
  endtask : run_add

  // Stalls between bytes prove the decoder only counts valid bytes.
  task automatic run_adc;
    u_fetch.gap = 2;
    feed('{8'h12, 8'h47, 8'h05, 8'h81, 8'hD1, 8'hCD, 8'hAB, 8'h15, 8'h22, 8'h11});
    feed('{8'h82, 8'hD0, 8'h9C});
    await(1'b0, 0);
    fields(AOD_OP_ADC, AOD_FORM_REGMEM, 8'h12, 4'h9, 8'h47, 1, 0, 16'h0000);
    await(1'b0, 0);
    fields(AOD_OP_ADC, AOD_FORM_IMMRM, 8'h81, 4'h5, 8'hD1, 0, 2, 16'hABCD);
    await(1'b0, 0);
    fields(AOD_OP_ADC, AOD_FORM_ACCUM, 8'h15, 4'hC, 8'h00, 0, 2, 16'h1122);
    await(1'b0, 0);
    fields(AOD_OP_ADC, AOD_FORM_IMMRM, 8'h82, 4'h3, 8'hD0, 0, 1, 16'h009C);
    u_fetch.gap = 0;
  endtask : run_adc

  task automatic run_single;
    aod_op_e    k[3];
    logic [7:0] opc[3];
    k = '{AOD_OP_AAA, AOD_OP_DAA, AOD_OP_AAS};
    opc = '{8'h37, 8'h27, 8'h3F};
    feed('{8'h37, 8'h27, 8'h3F});
    for (int i = 0; i < 3; i++) begin
      await(1'b0, 1);
      fields(k[i], AOD_FORM_SINGLE, opc[i], 4'h0, 8'h00, 0, 0, 16'h0000);
    end
  endtask : run_single

  task automatic run_sub;
    feed('{8'h2A, 8'hC3, 8'h80, 8'hE9, 8'h07, 8'h2C, 8'h7F, 8'h2D, 8'h00, 8'h80});
    await(1'b0, 2);
    fields(AOD_OP_SUB, AOD_FORM_REGMEM, 8'h2A, 4'h9, 8'hC3, 0, 0, 16'h0000);
    await(1'b0, 3);
    fields(AOD_OP_SUB, AOD_FORM_IMMRM, 8'h80, 4'h1, 8'hE9, 0, 1, 16'h0007);
    await(1'b0, 2);
    fields(AOD_OP_SUB, AOD_FORM_ACCUM, 8'h2C, 4'h8, 8'h00, 0, 1, 16'h007F);
    await(1'b0, 3);
    fields(AOD_OP_SUB, AOD_FORM_ACCUM, 8'h2D, 4'hC, 8'h00, 0, 2, 16'h8000);
  endtask : run_sub

  task automatic run_sbb;
    feed('{8'h19, 8'h4F, 8'h10, 8'h83, 8'hD8, 8'h80, 8'h83, 8'h98, 8'h00, 8'h10,
           8'h7F, 8'h1C, 8'h05});
    await(1'b0, 3);
    fields(AOD_OP_SBB, AOD_FORM_REGMEM, 8'h19, 4'h5, 8'h4F, 1, 0, 16'h0000);
    await(1'b0, 3);
    fields(AOD_OP_SBB, AOD_FORM_IMMRM, 8'h83, 4'h7, 8'hD8, 0, 1, 16'hFF80);
    await(1'b0, 5);
    fields(AOD_OP_SBB, AOD_FORM_IMMRM, 8'h83, 4'h7, 8'h98, 2, 1, 16'h007F);
    await(1'b0, 0);
    fields(AOD_OP_SBB, AOD_FORM_ACCUM, 8'h1C, 4'h8, 8'h00, 0, 1, 16'h0005);
  endtask : run_sbb

  // Compare in the immediate group and increment must not pass as arithmetic.
  task automatic run_foreign;
    feed('{8'h90, 8'h80, 8'hF8, 8'h40, 8'h3F});
    await(1'b1, 1);
    chk("heldKind", opKind, AOD_OP_SBB);
    await(1'b1, 2);
    await(1'b1, 1);
    await(1'b0, 1);
    chk("resyncKind", opKind, AOD_OP_AAS);
  endtask : run_foreign

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (5) @(negedge clk);
    chk("resetPulses", {instrValid, foreignValid, immValue[13:0]}, 16'h0000);
    chk("resetKind", opKind, AOD_OP_ADD);
    reset_n = 1'b1;
    run_add();
    run_adc();
    run_single();
    run_sub();
    run_sbb();
    run_foreign();
    wrap_up();
  end

  // The whole run needs about a hundred cycles; 2000 leaves ample margin.
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end
endmodule : arith_opcode_decoder_tb
